// file: rtl/nct_pkg.sv
/*
  Shared constants of the nibble core: machine-cycle phases, opcode map,
  output-operation selectors, carrier table, watchdog length, reset values.
  Assumes one oscillator clock drives every module of the core.
*/
package nct_pkg;
  // --------------------------------------------------------------
  // Machine cycle
  // --------------------------------------------------------------
  localparam logic [2:0] PHASE_FIRST = 3'h0;
  localparam logic [2:0] PHASE_DECIDE = 3'h2;
  localparam logic [2:0] PHASE_WRITE = 3'h4;
  localparam logic [2:0] PHASE_LAST = 3'h5;
  localparam int POR_MIN_MCYCLES = 4;
  localparam int WDT_STAGES = 14;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [9:0] DRIVE_RST = 10'h000;
  localparam logic [3:0] BIDIR_RST = 4'hf;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic STATUS_RST = 1'b1;

  // --------------------------------------------------------------
  // Opcodes
  // --------------------------------------------------------------
  localparam logic [3:0] F3_CMP_Y = 4'h3;
  localparam logic [3:0] F3_LD_Y = 4'h4;
  localparam logic [3:0] F3_STORE_INC = 4'h5;
  localparam logic [3:0] F3_LD_PAGE = 4'h6;
  localparam logic [3:0] F3_A_LE = 4'h7;
  localparam logic [2:0] F2_LOAD_X = 3'h4;
  localparam logic [2:0] F2_SET_BIT = 3'h5;
  localparam logic [2:0] F2_CLR_BIT = 3'h2;
  localparam logic [2:0] F2_TEST_BIT = 3'h3;
  typedef enum logic [7:0] {
    OP_LD_A_Y = 8'h00, OP_LD_Y_A = 8'h01, OP_CLR_A = 8'h02,
    OP_STORE_A = 8'h03, OP_STORE_A_INC = 8'h04, OP_LD_Y_M = 8'h05,
    OP_LD_A_M = 8'h06, OP_XCHG_M_A = 8'h07, OP_RETURN = 8'h08,
    OP_ADD_M = 8'h09, OP_SUB_M = 8'h0a, OP_INC_M = 8'h0b,
    OP_DEC_M = 8'h0c, OP_INC_A = 8'h0d, OP_INC_Y = 8'h0e,
    OP_DEC_A = 8'h0f, OP_DEC_Y = 8'h12, OP_XOR_M = 8'h13,
    OP_NEGATE = 8'h16, OP_A_LE_M = 8'h17, OP_M_NZ = 8'h1a,
    OP_Y_NE_A = 8'h1b, OP_K_NZ = 8'h1e, OP_R_NZ = 8'h1f,
    OP_LD_A_K = 8'h22, OP_LD_A_R = 8'h23, OP_SET_OUT = 8'h26,
    OP_RESET_OUT = 8'h27, OP_WD_CLEAR = 8'h2a, OP_STOP = 8'h2b,
    OP_LD_MODE = 8'h2e, OP_NOP = 8'h2f
  } nct_op_t;

  // --------------------------------------------------------------
  // Output-operation selectors and carrier table
  // --------------------------------------------------------------
  localparam logic [3:0] Y_CARRIER = 4'h8;
  localparam logic [3:0] Y_ALL_DRIVE = 4'h9;
  localparam logic [3:0] Y_ALL_BIDIR = 4'he;
  localparam logic [3:0] Y_EVERYTHING = 4'hf;
  localparam logic [3:0] CAR_STATIC_MODE = 4'h5;
  localparam logic [3:0] CAR_PERIOD [0:4] = '{4'hc, 4'hc, 4'h8, 4'h8, 4'hb};
  localparam logic [3:0] CAR_HIGH [0:4] = '{4'h6, 4'h4, 4'h4, 4'h2, 4'h4};
endpackage

// file: rtl/nct_link_if.sv
/*
  Bundle between the core and its carrier and watchdog helpers.
  Assumes all three sit on the same clock.
*/
interface nct_link_if;
  logic car_en;
  logic [3:0] car_mode;
  logic car_pin;
  logic wd_tick;
  logic wd_clear;
  logic wd_hold;
  logic wd_fire;
  modport core (output car_en, car_mode, wd_tick, wd_clear, wd_hold,
                input car_pin, wd_fire);
  modport carrier (input car_en, car_mode, output car_pin);
  modport wdog (input wd_tick, wd_clear, wd_hold, output wd_fire);
endinterface

// file: rtl/nct_carrier.sv
/*
  Carrier generator for the high-current output.
  Assumes mode and enable come from core registers; reset is the core's.
*/
module nct_carrier (
  input wire logic clk,
  input wire logic srst,
  nct_link_if.carrier lnk
);
  logic [3:0] cnt_q, cnt_d, period, high;
  logic pin_q, pin_d, stat;

  // --------------------------------------------------------------
  // Period counter
  // --------------------------------------------------------------
  always_comb
  begin
    stat = lnk.car_mode >= nct_pkg::CAR_STATIC_MODE;
    period = stat ? 4'h1 : nct_pkg::CAR_PERIOD[lnk.car_mode[2:0]];
    high = stat ? 4'h1 : nct_pkg::CAR_HIGH[lnk.car_mode[2:0]];
    // period and duty
    // A counter past the new period after a mode change wraps at once
    cnt_d = (!lnk.car_en || cnt_q >= period - 4'h1) ? 4'h0 : cnt_q + 4'h1;
    pin_d = lnk.car_en && (stat || cnt_q < high);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q <= 4'h0;
      pin_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pin_q <= pin_d;
    end
  end

  assign lnk.car_pin = pin_q;

  sequence s_rise_mode0;
    $rose(lnk.car_pin) && lnk.car_en && lnk.car_mode == 4'h0;
  endsequence
  sequence s_held_mode0;
    (lnk.car_en && lnk.car_mode == 4'h0) [*5];
  endsequence
  carrier_half_a: assert property (
    @(posedge clk) disable iff (srst)
    s_rise_mode0 ##1 s_held_mode0 |=> !lnk.car_pin)
    else $error("mode 0 carrier high phase not six clocks");
  carrier_static_a: assert property (
    @(posedge clk) disable iff (srst)
    lnk.car_en && lnk.car_mode == 4'h5 |=> lnk.car_pin || !lnk.car_en)
    else $error("static carrier mode did not hold output high");
endmodule

// file: rtl/nct_wdog.sv
/*
  Watchdog counter, advanced once per machine cycle.
  Assumes the core supplies the tick, clear and stop-hold levels.
*/
module nct_wdog #(
  parameter int STAGES = nct_pkg::WDT_STAGES
) (
  input wire logic clk,
  input wire logic srst,
  nct_link_if.wdog lnk
);
  logic [STAGES-1:0] cnt_q, cnt_d;
  logic fire_q, fire_d, zap;

  always_comb
  begin
    zap = lnk.wd_clear || lnk.wd_hold || cnt_q[STAGES-1];
    fire_d = cnt_q[STAGES-1] && !lnk.wd_clear && !lnk.wd_hold;
    cnt_d = zap ? '0 : (lnk.wd_tick ? cnt_q + 1'b1 : cnt_q);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q <= '0;
      fire_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      fire_q <= fire_d;
    end
  end

  assign lnk.wd_fire = fire_q;

  wdog_fire_a: assert property (
    @(posedge clk) disable iff (srst)
    fire_q |-> cnt_q == '0 && $past(cnt_q[STAGES-1]))
    else $error("watchdog fired without overflow");
  wdog_hold_a: assert property (
    @(posedge clk) disable iff (srst)
    lnk.wd_hold |=> cnt_q == '0 && !fire_q)
    else $error("watchdog counted during stop");
endmodule

// file: rtl/nct_core.sv
/*
  Nibble core: machine-cycle sequencer, decoder, status logic, output
  set/reset operations, carrier mode register and watchdog hookup.
  Assumes program ROM and data RAM outside answer combinationally,
  and all inputs are synchronous to clk.
*/
// What this block does
// - Each instruction fetches in six clocks, executes in the next six.
// - Taken branch, call and return refetch early to keep uniform time.
// - First format: whole byte is opcode.
// - Second format: two-bit operand selects RAM bit or page pointer.
// - Third format: four-bit constant, compare value or program page.
// - Fourth format: six-bit word address within the program page.
// - Forty-three instructions; constants 0..f, selectors 0..3, 6-bit targets.
// - Plain class always sets status; carry class sets on carry.
// - No-borrow class sets status only when no borrow occurs.
// - Less-or-equal class sets on A <= operand, inequality class on different.
// - Negate sets status only when its result is zero.
// - Page 0/1: index 0-7 one drive line, 9 all, A-D one bidir.
// - Page 0/1, index E: all four bidir lines together.
// - Page 2/3: index 0 drives line 8, index 1 line 9.
// - Page 0/1, index 8: set starts carrier, reset stops it.
// - Carrier period and high fraction follow the carrier mode.
// - Mode 5 gives no pulses, output held high while enabled.
// - Carrier mode resets to 0; load-mode copies index pointer.
// - Watchdog is 14 stages at clock/6 and resets the core.
// - Watchdog clears on its instruction, optionally on carrier set.
// - Watchdog held clear in stop, resumes after release.
module nct_core #(
  parameter int WDT_STAGES = nct_pkg::WDT_STAGES,
  parameter bit WDOG_BY_CARRIER = 1'b1
) (
  input wire logic clk,
  input wire logic srst,
  output logic [9:0] rom_addr,
  input wire logic [7:0] rom_data,
  output logic [4:0] ram_addr,
  output logic [3:0] ram_wdata,
  output logic ram_we,
  input wire logic [3:0] ram_rdata,
  input wire logic [3:0] key_inputs,
  input wire logic [3:0] bidir_in,
  output logic [3:0] bidir_out,
  output logic [3:0] bidir_oe,
  output logic [9:0] drive_out,
  output logic [9:0] drive_oe,
  output logic carrier_out_pin,
  output logic status_flag,
  output logic stop_active
);
  nct_link_if lnk ();
  logic core_rst;
  logic [2:0] phase_q, phase_d;
  logic [7:0] instr_q, instr_d;
  logic [5:0] pc_q, pc_d;
  logic [3:0] pa_q, pa_d, pb_q, pb_d;
  logic [2:0][9:0] stk_q, stk_d;
  logic [9:0] rom_addr_q, rom_addr_d, target;
  logic [3:0] a_q, a_d, y_q, y_d, mode_q, mode_d, bidir_q, bidir_d;
  logic [1:0] x_q, x_d;
  logic st_q, st_d, car_en_q, car_en_d, stop_q, stop_d;
  logic [9:0] drive_q, drive_d;
  logic we_q, we_d, mem_we, wd_clear, taken, exec, lvl;
  logic [3:0] wdata_q, wdata_d, mem_wdata;
  logic [4:0] sum;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // watchdog reset same as external
  assign core_rst = srst | lnk.wd_fire;

  nct_carrier u_carrier (
    .clk(clk),
    .srst(core_rst),
    .lnk(lnk)
  );

  nct_wdog #(
    .STAGES(WDT_STAGES)
  ) u_wdog (
    .clk(clk),
    .srst(srst),
    .lnk(lnk)
  );

  // Stop mode forces the carrier low without losing its enable
  assign lnk.car_en = car_en_q && !stop_q;
  assign lnk.car_mode = mode_q;
  assign lnk.wd_tick = exec;
  assign lnk.wd_clear = wd_clear;
  assign lnk.wd_hold = stop_q;

  // --------------------------------------------------------------
  // Sequencing and branch redirect
  // --------------------------------------------------------------
  always_comb
  begin
    exec = phase_q == nct_pkg::PHASE_LAST && !stop_q;
    if (stop_q)
      phase_d = phase_q;
    else if (phase_q == nct_pkg::PHASE_LAST)
      phase_d = nct_pkg::PHASE_FIRST;
    else
      phase_d = phase_q + 3'h1;
    // page from buffer, word from operand
    if (instr_q[7])
    begin
      taken = st_q;
      target = {pb_q, instr_q[5:0]};
    end
    else
    begin
      taken = instr_q == nct_pkg::OP_RETURN;
      target = stk_q[0];
    end
  end

  // --------------------------------------------------------------
  // Execute
  // --------------------------------------------------------------
  always_comb
  begin
    a_d = a_q;
    y_d = y_q;
    x_d = x_q;
    st_d = st_q;
    pb_d = pb_q;
    stk_d = stk_q;
    drive_d = drive_q;
    bidir_d = bidir_q;
    car_en_d = car_en_q;
    mode_d = mode_q;
    stop_d = stop_q;
    instr_d = instr_q;
    pc_d = pc_q;
    pa_d = pa_q;
    rom_addr_d = rom_addr_q;
    mem_we = 1'b0;
    mem_wdata = a_q;
    wd_clear = 1'b0;
    sum = 5'h00;
    lvl = instr_q == nct_pkg::OP_SET_OUT;
    if (stop_q && (key_inputs != 4'hf || bidir_in != 4'hf))
      stop_d = 1'b0;
    if (phase_q == nct_pkg::PHASE_DECIDE && !stop_q && taken)
      rom_addr_d = target;
    if (exec)
    begin
      st_d = 1'b1;
      instr_d = rom_data;
      pc_d = taken ? target[5:0] + 6'h01 : pc_q + 6'h01;
      pa_d = taken ? target[9:6] : pa_q;
      rom_addr_d = {pa_d, pc_d};
      if (instr_q[7])
      begin
        if (instr_q[6] && st_q)
          stk_d = {stk_q[1], stk_q[0], pa_q, pc_q};
      end
      else if (instr_q[6] || instr_q[7:4] == nct_pkg::F3_CMP_Y)
      begin
        case (instr_q[7:4])
          nct_pkg::F3_LD_Y: y_d = instr_q[3:0];
          nct_pkg::F3_STORE_INC:
          begin
            mem_we = 1'b1;
            mem_wdata = instr_q[3:0];
            y_d = y_q + 4'h1;
          end
          nct_pkg::F3_LD_PAGE: pb_d = instr_q[3:0];
          nct_pkg::F3_A_LE: st_d = a_q <= instr_q[3:0];
          default: st_d = y_q != instr_q[3:0];
        endcase
      end
      else if (!instr_q[1] && instr_q[7:4] != 4'h0)
      begin
        case ({instr_q[5:4], instr_q[0]})
          nct_pkg::F2_LOAD_X: x_d = instr_q[3:2];
          nct_pkg::F2_SET_BIT:
          begin
            mem_we = 1'b1;
            mem_wdata = ram_rdata | (4'h1 << instr_q[3:2]);
          end
          nct_pkg::F2_CLR_BIT:
          begin
            mem_we = 1'b1;
            mem_wdata = ram_rdata & ~(4'h1 << instr_q[3:2]);
          end
          default: st_d = ram_rdata[instr_q[3:2]];
        endcase
      end
      else
      begin
        case (instr_q)
          nct_pkg::OP_LD_A_Y: a_d = y_q;
          nct_pkg::OP_LD_Y_A: y_d = a_q;
          nct_pkg::OP_CLR_A: a_d = 4'h0;
          nct_pkg::OP_STORE_A: mem_we = 1'b1;
          nct_pkg::OP_STORE_A_INC:
          begin
            mem_we = 1'b1;
            y_d = y_q + 4'h1;
          end
          nct_pkg::OP_LD_Y_M: y_d = ram_rdata;
          nct_pkg::OP_LD_A_M: a_d = ram_rdata;
          nct_pkg::OP_XCHG_M_A:
          begin
            a_d = ram_rdata;
            mem_we = 1'b1;
          end
          nct_pkg::OP_ADD_M:
          begin
            sum = {1'b0, a_q} + {1'b0, ram_rdata};
            a_d = sum[3:0];
            st_d = sum[4];
          end
          nct_pkg::OP_INC_M:
          begin
            sum = {1'b0, ram_rdata} + 5'h01;
            a_d = sum[3:0];
            st_d = sum[4];
          end
          nct_pkg::OP_INC_Y:
          begin
            sum = {1'b0, y_q} + 5'h01;
            y_d = sum[3:0];
            st_d = sum[4];
          end
          nct_pkg::OP_SUB_M:
          begin
            sum = {1'b0, ram_rdata} - {1'b0, a_q};
            a_d = sum[3:0];
            st_d = !sum[4];
          end
          nct_pkg::OP_DEC_M:
          begin
            sum = {1'b0, ram_rdata} - 5'h01;
            a_d = sum[3:0];
            st_d = !sum[4];
          end
          nct_pkg::OP_DEC_A:
          begin
            sum = {1'b0, a_q} - 5'h01;
            a_d = sum[3:0];
            st_d = !sum[4];
          end
          nct_pkg::OP_DEC_Y:
          begin
            sum = {1'b0, y_q} - 5'h01;
            y_d = sum[3:0];
            st_d = !sum[4];
          end
          nct_pkg::OP_INC_A: a_d = a_q + 4'h1;
          nct_pkg::OP_XOR_M: a_d = a_q ^ ram_rdata;
          nct_pkg::OP_NEGATE:
          begin
            a_d = 4'h0 - a_q;
            st_d = a_d == 4'h0;
          end
          nct_pkg::OP_A_LE_M: st_d = a_q <= ram_rdata;
          nct_pkg::OP_M_NZ: st_d = ram_rdata != 4'h0;
          nct_pkg::OP_Y_NE_A: st_d = y_q != a_q;
          nct_pkg::OP_K_NZ: st_d = key_inputs != 4'h0;
          nct_pkg::OP_R_NZ: st_d = bidir_in != 4'h0;
          nct_pkg::OP_LD_A_K: a_d = key_inputs;
          nct_pkg::OP_LD_A_R: a_d = bidir_in;
          nct_pkg::OP_SET_OUT, nct_pkg::OP_RESET_OUT:
          begin
            if (x_q[1])
            begin
              if (y_q == 4'h0)
                drive_d[8] = lvl;
              else if (y_q == 4'h1)
                drive_d[9] = lvl;
            end
            else if (!y_q[3])
              drive_d[y_q[2:0]] = lvl;
            else
              case (y_q)
                nct_pkg::Y_CARRIER:
                begin
                  car_en_d = lvl;
                  wd_clear = lvl && WDOG_BY_CARRIER;
                end
                nct_pkg::Y_ALL_DRIVE: drive_d = {10{lvl}};
                nct_pkg::Y_ALL_BIDIR: bidir_d = {4{lvl}};
                nct_pkg::Y_EVERYTHING:
                begin
                  drive_d = {10{lvl}};
                  bidir_d = {4{lvl}};
                end
                default: bidir_d[y_q[1:0] - 2'h2] = lvl;
              endcase
          end
          nct_pkg::OP_WD_CLEAR: wd_clear = 1'b1;
          // An input already low turns stop into a no-op
          nct_pkg::OP_STOP:
            stop_d = key_inputs == 4'hf && bidir_in == 4'hf;
          nct_pkg::OP_LD_MODE: mode_d = y_q;
          // Return pops one level so nested calls unwind in order
          nct_pkg::OP_RETURN: stk_d = {stk_q[2], stk_q[2], stk_q[1]};
          default: st_d = 1'b1;
        endcase
      end
    end
    we_d = phase_q == nct_pkg::PHASE_WRITE && !stop_q && mem_we;
    wdata_d = mem_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (core_rst)
    begin
      phase_q <= nct_pkg::PHASE_FIRST;
      instr_q <= nct_pkg::OP_NOP;
      pc_q <= 6'h00;
      pa_q <= 4'h0;
      pb_q <= 4'h0;
      stk_q <= '0;
      rom_addr_q <= 10'h000;
      a_q <= 4'h0;
      y_q <= 4'h0;
      x_q <= 2'h0;
      st_q <= nct_pkg::STATUS_RST;
      drive_q <= nct_pkg::DRIVE_RST;
      bidir_q <= nct_pkg::BIDIR_RST;
      car_en_q <= 1'b0;
      mode_q <= nct_pkg::MODE_RST;
      stop_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= 4'h0;
    end
    else
    begin
      phase_q <= phase_d;
      instr_q <= instr_d;
      pc_q <= pc_d;
      pa_q <= pa_d;
      pb_q <= pb_d;
      stk_q <= stk_d;
      rom_addr_q <= rom_addr_d;
      a_q <= a_d;
      y_q <= y_d;
      x_q <= x_d;
      st_q <= st_d;
      drive_q <= drive_d;
      bidir_q <= bidir_d;
      car_en_q <= car_en_d;
      mode_q <= mode_d;
      stop_q <= stop_d;
      we_q <= we_d;
      wdata_q <= wdata_d;
    end
  end

  // --------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------
  assign rom_addr = rom_addr_q;
  assign ram_addr = {x_q[0], y_q};
  assign ram_we = we_q;
  assign ram_wdata = wdata_q;
  // Open drain: a cleared latch pulls low, a set one releases, but stop pulls drive lines 8 and 9 low
  assign bidir_out = 4'h0;
  assign bidir_oe = ~bidir_q;
  assign drive_out = 10'h000;
  assign drive_oe = ~drive_q | {stop_q, stop_q, 8'h00};
  assign carrier_out_pin = lnk.car_pin;
  assign status_flag = st_q;
  assign stop_active = stop_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (core_rst);

  phase_wrap_a: assert property (
    phase_q == 3'h5 |=> phase_q == 3'h0)
    else $error("machine cycle not six clocks");
  instr_once_a: assert property (
    $changed(instr_q) && !$past(core_rst) |-> $past(phase_q) == 3'h5)
    else $error("instruction loaded outside last phase");
  redirect_a: assert property (
    phase_q == 3'h2 && taken && !stop_q |=> rom_addr == $past(target))
    else $error("branch target not fetched in time");
  carry_flag_a: assert property (
    exec && instr_q == nct_pkg::OP_ADD_M
    |=> st_q == ($past(a_q) + $past(ram_rdata) > 15))
    else $error("carry status wrong");
  borrow_flag_a: assert property (
    exec && instr_q == nct_pkg::OP_DEC_A |=> st_q == ($past(a_q) != 4'h0))
    else $error("no-borrow status wrong");
  negate_flag_a: assert property (
    exec && instr_q == nct_pkg::OP_NEGATE |=> st_q == (a_q == 4'h0))
    else $error("negate status wrong");
  drive_line_a: assert property (
    exec && instr_q == nct_pkg::OP_SET_OUT && !x_q[1] && !y_q[3]
    |=> drive_q[$past(y_q[2:0])])
    else $error("drive line not released");
  carrier_run_a: assert property (
    exec && instr_q == nct_pkg::OP_RESET_OUT && !x_q[1] && y_q == 4'h8
    |=> !car_en_q ##1 !carrier_out_pin)
    else $error("carrier not stopped");
  mode_load_a: assert property (
    exec && instr_q == nct_pkg::OP_LD_MODE |=> mode_q == $past(y_q))
    else $error("carrier mode not loaded");
endmodule

// file: verification/nct_mem_model.sv
/*
  Program ROM, data RAM and bidir pull-ups facing the nibble core.
  Assumes the bench loads the ROM before reset is released.
*/
module nct_mem_model (
  input wire logic clk,
  input wire logic [9:0] rom_addr,
  output logic [7:0] rom_data,
  input wire logic [4:0] ram_addr,
  input wire logic [3:0] ram_wdata,
  input wire logic ram_we,
  output logic [3:0] ram_rdata,
  input wire logic [3:0] bidir_oe,
  output logic [3:0] bidir_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rom [0:1023];
  logic [3:0] ram [0:31];
  // ----------------------------------------------------------
  // Storage
  // ----------------------------------------------------------
  // Reads are combinational, as the core samples them in phase 5
  assign rom_data = rom[rom_addr];
  assign ram_rdata = ram[ram_addr];
  always @(posedge clk)
  begin
    if (ram_we)
      ram[ram_addr] <= ram_wdata;
  end
  // Open drain with pull-up: released lines read high
  assign bidir_in = ~bidir_oe;
endmodule

// file: verification/testbench.sv
/*
  Self-checking bench of the nibble core running a small program.
  Assumes one clock at 125 MHz and a reduced watchdog length.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] key_inputs = 4'hf;
  logic [9:0] rom_addr, drive_out, drive_oe;
  logic [7:0] rom_data;
  logic [4:0] ram_addr;
  logic [3:0] ram_wdata, ram_rdata, bidir_in, bidir_out, bidir_oe;
  logic ram_we, carrier_out_pin, status_flag, stop_active;
  int cyc = 0;
  int err_count = 0;
  int comparisons = 0;
  // Watchdog shortened to 32 machine cycles so its reset is seen
  nct_core #(.WDT_STAGES(6), .WDOG_BY_CARRIER(1'b1)) u_nct_core (
    .clk(clk), .srst(srst), .rom_addr(rom_addr), .rom_data(rom_data),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
    .ram_rdata(ram_rdata), .key_inputs(key_inputs), .bidir_in(bidir_in),
    .bidir_out(bidir_out), .bidir_oe(bidir_oe), .drive_out(drive_out),
    .drive_oe(drive_oe), .carrier_out_pin(carrier_out_pin),
    .status_flag(status_flag), .stop_active(stop_active));
  nct_mem_model u_nct_mem_model (
    .clk(clk), .rom_addr(rom_addr), .rom_data(rom_data),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we),
    .ram_rdata(ram_rdata), .bidir_oe(bidir_oe), .bidir_in(bidir_in));
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
    cyc <= srst ? 0 : cyc + 1;
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(string what, logic [9:0] exp, logic [9:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  // Sample mid machine cycle, clear of any edge of change
  task automatic at(int k);
    while (cyc < 6 * k + 15)
      @(negedge clk);
  endtask
  task automatic highs(int n, logic [9:0] exp);
    int h;
    h = 0;
    repeat (n)
    begin
      @(negedge clk);
      h += int'(carrier_out_pin);
    end
    check("carrier highs", exp, 10'(h));
  endtask
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
  initial
  begin
    logic [7:0] prog [0:31];
    prog = '{8'h49, 8'h26, 8'h43, 8'h27, 8'h4b, 8'h27, 8'h4e, 8'h26,
             8'h28, 8'h40, 8'h27, 8'h20, 8'h2a, 8'h48, 8'h26, 8'h2f,
             8'h2f, 8'h43, 8'h2e, 8'h48, 8'h2f, 8'h2f, 8'h45, 8'h35,
             8'h36, 8'h02, 8'h35, 8'h16, 8'h0d, 8'h16, 8'h2f, 8'h9f};
    #1;
    for (int i = 0; i < 1024; i++)
      u_nct_mem_model.rom[i] = (i < 32) ? prog[i] : 8'h2f;
    // ----------------------------------------------------------
    // Reset and output operations
    // ----------------------------------------------------------
    // reset held beyond four machine cycles
    repeat (30) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check("status", 10'h001, 10'(status_flag));
    at(1);
    check("drive_oe", 10'h000, drive_oe);
    at(3);
    check("drive_oe", 10'h008, drive_oe);
    at(5);
    check("bidir_oe", 10'h002, 10'(bidir_oe));
    at(7);
    check("bidir_oe", 10'h000, 10'(bidir_oe));
    at(10);
    check("drive_oe", 10'h108, drive_oe);
    $display("test outputs done");
    // ----------------------------------------------------------
    // Carrier modes
    // ----------------------------------------------------------
    at(15);
    highs(12, 10'd6);
    at(21);
    highs(8, 10'd2);
    $display("test carrier done");
    // ----------------------------------------------------------
    // Status flag classes
    // ----------------------------------------------------------
    at(23);
    check("status", 10'h000, 10'(status_flag));
    at(24);
    check("status", 10'h001, 10'(status_flag));
    at(26);
    check("status", 10'h000, 10'(status_flag));
    at(27);
    check("status", 10'h001, 10'(status_flag));
    at(28);
    check("status", 10'h001, 10'(status_flag));
    at(29);
    check("status", 10'h000, 10'(status_flag));
    check("drive_oe", 10'h108, drive_oe);
    $display("test status done");
    // ----------------------------------------------------------
    // Watchdog overflow in a tight loop
    // ----------------------------------------------------------
    for (int i = 0; i < 300 && drive_oe !== 10'h3ff; i++)
      @(negedge clk);
    check("drive_oe", 10'h3ff, drive_oe);
    check("carrier", 10'h000, 10'(carrier_out_pin));
    check("status", 10'h001, 10'(status_flag));
    $display("test watchdog done");
    summarize();
  end
endmodule
